// ===== hw/bsc_top.sv
// battery switch-over control with avalon-mm register slave
// Operation
// - pms code picks standard, direct or disabled mode and low detection; 111 after reset
// - standard mode: battery only when vdd below battery and below switch threshold
// - direct mode: battery whenever vdd below battery, threshold not looked at
// - switching to battery sets the battery switch flag
// - switch interrupt raised while switch irq enable is set, or from its sticky status bit while that mask bit is set
// - switch with timestamp enable captures current time into timestamp register
// - switch flag stays until software clears it or switch-over is disabled; clearing drops its enable-gated interrupt
// - on battery: host inputs ignored, host outputs high-z, square wave off
// - switch-over disabled: flag held 0, supply stays on main
// - low detection enabled and battery low sets low flag, irq if enabled
// - low flag ignores software clears; clears when battery back above threshold
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module bsc_top
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [BSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BSC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [BSC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // asynchronous supply comparators
  input wire logic vdd_below_vbat,
  input wire logic vdd_below_vth,
  input wire logic vbat_low,
  // current time and date from the clock core
  input wire logic [BSC_TIME_W-1:0] current_time,
  // supply and gating outputs
  output logic backed_supply_output,
  output logic host_in_enable,
  output logic host_out_enable,
  output logic square_wave_output_enable,
  // interrupt
  output logic irq
);

  logic [BSC_CTRL_PMS_W-1:0] power_mgmt_select_r;
  logic battery_switch_irq_enable_r;
  logic battery_switch_timestamp_enable_r;
  logic battery_low_irq_enable_r;
  logic battery_switch_flag_r;
  logic battery_low_flag_r;
  logic [BSC_IRQ_W-1:0] irq_status_r;
  logic [BSC_IRQ_W-1:0] irq_mask_r;
  logic [BSC_TIME_W-1:0] timestamp_r;
  logic on_battery_r;
  logic waitrequest_r;
  logic [BSC_DATA_W-1:0] readdata_r;
  logic irq_r;

  logic [BSC_CMP_W-1:0] cmp_meta_r;
  logic [BSC_CMP_W-1:0] cmp_s2_r;
  logic [BSC_CMP_W-1:0] cmp_s3_r;
  logic [BSC_CMP_W-1:0] cmp_r;

  bsc_mode_e mode;
  logic low_detect_en;
  logic on_battery_nxt;
  logic switch_event;
  logic req;
  logic wr_fire;
  logic rd_fire;
  logic [BSC_DATA_W-1:0] rd_mux;
  logic [BSC_IRQ_W-1:0] irq_events;
  logic [BSC_IRQ_W-1:0] irq_read_clr;
  logic switch_clr;

  // three-stage synchroniser, value taken once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_meta_r <= '0;
      cmp_s2_r <= '0;
      cmp_s3_r <= '0;
      cmp_r <= '0;
    end else begin
      cmp_meta_r <= {vbat_low, vdd_below_vth, vdd_below_vbat};
      cmp_s2_r <= cmp_meta_r;
      cmp_s3_r <= cmp_s2_r;
      for (int i = 0; i < BSC_CMP_W; i++) begin
        if (cmp_s2_r[i] == cmp_s3_r[i]) begin
          cmp_r[i] <= cmp_s3_r[i];
        end
      end
    end
  end

  // mode decode
  always_comb begin
    mode = BSC_MODE_OFF;
    low_detect_en = 1'b0;
    unique case (power_mgmt_select_r)
      BSC_PMS_STD_LOW: begin
        mode = BSC_MODE_STD;
        low_detect_en = 1'b1;
      end
      BSC_PMS_STD_A, BSC_PMS_STD_B: begin
        mode = BSC_MODE_STD;
      end
      BSC_PMS_DIR_LOW: begin
        mode = BSC_MODE_DIRECT;
        low_detect_en = 1'b1;
      end
      BSC_PMS_DIR_A, BSC_PMS_DIR_B: begin
        mode = BSC_MODE_DIRECT;
      end
      BSC_PMS_OFF_A, BSC_PMS_OFF_B: begin
        mode = BSC_MODE_OFF;
      end
    endcase
  end

  // supply selection; direct mode assumes vdd normally well above the battery
  always_comb begin
    unique case (mode)
      BSC_MODE_STD: begin
        on_battery_nxt = cmp_r[BSC_CMP_BELOW_VBAT] & cmp_r[BSC_CMP_BELOW_VTH];
      end
      BSC_MODE_DIRECT: begin
        on_battery_nxt = cmp_r[BSC_CMP_BELOW_VBAT];
      end
      default: begin
        on_battery_nxt = 1'b0;
      end
    endcase
  end

  assign switch_event = on_battery_nxt & ~on_battery_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      on_battery_r <= 1'b0;
    end else begin
      on_battery_r <= on_battery_nxt;
    end
  end

  // supply and interface gating, all registered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      backed_supply_output <= 1'b0;
      host_in_enable <= 1'b1;
      host_out_enable <= 1'b1;
      square_wave_output_enable <= 1'b1;
    end else begin
      backed_supply_output <= on_battery_nxt;
      host_in_enable <= ~on_battery_nxt;
      host_out_enable <= ~on_battery_nxt;
      square_wave_output_enable <= ~on_battery_nxt;
    end
  end

  // avalon slave: one wait state on every access
  assign req = avs_read | avs_write;
  assign wr_fire = avs_write & ~waitrequest_r;
  assign rd_fire = avs_read & ~waitrequest_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= ~(req & waitrequest_r);
    end
  end

  assign avs_waitrequest = waitrequest_r;

  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      BSC_CTRL_ADDR: begin
        rd_mux[BSC_CTRL_PMS_LSB +: BSC_CTRL_PMS_W] = power_mgmt_select_r;
        rd_mux[BSC_CTRL_BSIE_BIT] = battery_switch_irq_enable_r;
        rd_mux[BSC_CTRL_BSTE_BIT] = battery_switch_timestamp_enable_r;
        rd_mux[BSC_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT] = battery_low_irq_enable_r;
      end
      BSC_FLAGS_ADDR: begin
        rd_mux[BSC_FLAG_SWITCH_BIT] = battery_switch_flag_r;
        rd_mux[BSC_FLAG_LOW_BIT] = battery_low_flag_r;
        rd_mux[BSC_FLAG_ON_BATT_BIT] = on_battery_r;
      end
      BSC_IRQ_STATUS_ADDR: begin
        rd_mux[BSC_IRQ_W-1:0] = irq_status_r;
      end
      BSC_IRQ_MASK_ADDR: begin
        rd_mux[BSC_IRQ_W-1:0] = irq_mask_r;
      end
      BSC_TIMESTAMP_ADDR: begin
        rd_mux = timestamp_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // snapshot taken in the wait cycle; read-clear uses the same snapshot
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata_r <= '0;
    end else if (avs_read & waitrequest_r) begin
      readdata_r <= rd_mux;
    end
  end

  assign avs_readdata = readdata_r;

  // control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_mgmt_select_r <= BSC_PMS_RESET;
      battery_switch_irq_enable_r <= 1'b0;
      battery_switch_timestamp_enable_r <= 1'b0;
      battery_low_irq_enable_r <= 1'b0;
    end else if (wr_fire && avs_address == BSC_CTRL_ADDR && avs_byteenable[0]) begin
      power_mgmt_select_r <= avs_writedata[BSC_CTRL_PMS_LSB +: BSC_CTRL_PMS_W];
      battery_switch_irq_enable_r <= avs_writedata[BSC_CTRL_BSIE_BIT];
      battery_switch_timestamp_enable_r <= avs_writedata[BSC_CTRL_BSTE_BIT];
      battery_low_irq_enable_r <= avs_writedata[BSC_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT];
    end
  end

  // switch flag: write one to clear, a new switch wins over the clear
  assign switch_clr = wr_fire && avs_address == BSC_FLAGS_ADDR && avs_byteenable[0]
                      && avs_writedata[BSC_FLAG_SWITCH_BIT];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      battery_switch_flag_r <= 1'b0;
    end else if (mode == BSC_MODE_OFF) begin
      battery_switch_flag_r <= 1'b0;
    end else if (switch_event) begin
      battery_switch_flag_r <= 1'b1;
    end else if (switch_clr) begin
      battery_switch_flag_r <= 1'b0;
    end
  end

  // low flag: no software clear path at all
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      battery_low_flag_r <= 1'b0;
    end else if (low_detect_en && cmp_r[BSC_CMP_VBAT_LOW]) begin
      battery_low_flag_r <= 1'b1;
    end else if (!cmp_r[BSC_CMP_VBAT_LOW]) begin
      battery_low_flag_r <= 1'b0;
    end
  end

  // timestamp capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timestamp_r <= '0;
    end else if (switch_event && battery_switch_timestamp_enable_r) begin
      timestamp_r <= current_time;
    end
  end

  // sticky event status, cleared by reading it
  always_comb begin
    irq_events = '0;
    irq_events[BSC_IRQ_SWITCH_BIT] = switch_event;
    irq_events[BSC_IRQ_LOW_BIT] = low_detect_en & cmp_r[BSC_CMP_VBAT_LOW] & ~battery_low_flag_r;
    irq_events[BSC_IRQ_TS_BIT] = switch_event & battery_switch_timestamp_enable_r;
    irq_read_clr = '0;
    if (rd_fire && avs_address == BSC_IRQ_STATUS_ADDR) begin
      irq_read_clr = readdata_r[BSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_read_clr) | irq_events;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_r <= BSC_MASK_RESET;
    end else if (wr_fire && avs_address == BSC_IRQ_MASK_ADDR && avs_byteenable[0]) begin
      irq_mask_r <= avs_writedata[BSC_IRQ_W-1:0];
    end
  end

  // flags drive the line while enabled, so a flag clear or an enable clear drops them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (|(irq_status_r & irq_mask_r))
               | (battery_switch_flag_r & battery_switch_irq_enable_r)
               | (battery_low_flag_r & battery_low_irq_enable_r);
    end
  end

  assign irq = irq_r;

endmodule

// ===== common/bsc_pkg.sv
// package for the battery switch-over control block
package bsc_pkg;

  // avalon register map, byte addresses
  localparam int BSC_ADDR_W = 5;
  localparam logic [BSC_ADDR_W-1:0] BSC_CTRL_ADDR = 5'h00;
  localparam logic [BSC_ADDR_W-1:0] BSC_FLAGS_ADDR = 5'h04;
  localparam logic [BSC_ADDR_W-1:0] BSC_IRQ_STATUS_ADDR = 5'h08;
  localparam logic [BSC_ADDR_W-1:0] BSC_IRQ_MASK_ADDR = 5'h0c;
  localparam logic [BSC_ADDR_W-1:0] BSC_TIMESTAMP_ADDR = 5'h10;

  localparam int BSC_DATA_W = 32;
  localparam int BSC_TIME_W = 32;

  // control register fields
  localparam int BSC_CTRL_PMS_LSB = 0;
  localparam int BSC_CTRL_PMS_W = 3;
  localparam int BSC_CTRL_BSIE_BIT = 3;
  localparam int BSC_CTRL_BSTE_BIT = 4;
  localparam int BSC_CTRL_BATTERY_LOW_IRQ_ENABLE_BIT = 5;

  // flags register fields
  localparam int BSC_FLAG_SWITCH_BIT = 0;
  localparam int BSC_FLAG_LOW_BIT = 1;
  localparam int BSC_FLAG_ON_BATT_BIT = 2;

  // interrupt status / mask fields
  localparam int BSC_IRQ_W = 3;
  localparam int BSC_IRQ_SWITCH_BIT = 0;
  localparam int BSC_IRQ_LOW_BIT = 1;
  localparam int BSC_IRQ_TS_BIT = 2;

  // reset values
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_RESET = 3'h7;
  localparam logic [BSC_IRQ_W-1:0] BSC_MASK_RESET = 3'h0;

  // power management selection codes
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_STD_LOW = 3'h0;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_STD_A = 3'h1;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_STD_B = 3'h2;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_DIR_LOW = 3'h3;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_DIR_A = 3'h4;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_DIR_B = 3'h5;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_OFF_A = 3'h6;
  localparam logic [BSC_CTRL_PMS_W-1:0] BSC_PMS_OFF_B = 3'h7;

  // switch-over modes
  typedef enum logic [1:0] {
    BSC_MODE_STD,
    BSC_MODE_DIRECT,
    BSC_MODE_OFF
  } bsc_mode_e;

  // comparator input count and bit positions
  localparam int BSC_CMP_W = 3;
  localparam int BSC_CMP_BELOW_VBAT = 0;
  localparam int BSC_CMP_BELOW_VTH = 1;
  localparam int BSC_CMP_VBAT_LOW = 2;

endpackage

// ===== verification/bsc_checker_assertions.sv
// concurrent checks on the switch-over control ports
`timescale 1ns/1ps
module bsc_checker
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register bus
  input wire logic [BSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BSC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [BSC_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // supply
  input wire logic vdd_below_vbat,
  input wire logic vdd_below_vth,
  input wire logic backed_supply_output,
  input wire logic host_in_enable,
  input wire logic host_out_enable,
  input wire logic square_wave_output_enable
);
  logic [2:0] pms_r;
  logic std;
  logic dir;
  // shadow of the selection field, mirrors accepted writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pms_r <= BSC_PMS_RESET;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == BSC_CTRL_ADDR) begin
      pms_r <= avs_writedata[2:0];
    end
  end
  assign std = pms_r < 3'h3;
  assign dir = pms_r > 3'h2 && pms_r < 3'h6;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("readdata changed without read");
  gate_follow_a: assert property (
    host_in_enable != backed_supply_output && host_out_enable != backed_supply_output
    && square_wave_output_enable != backed_supply_output) else $error("gating mismatch");
  off_main_a: assert property (
    (pms_r[2:1] == 2'b11)[*3] |-> !backed_supply_output) else $error("battery while off");
  std_main_a: assert property (
    (std && !vdd_below_vth)[*8] |-> !backed_supply_output) else $error("standard above vth");
  std_batt_a: assert property (
    (std && vdd_below_vbat && vdd_below_vth)[*8] |-> backed_supply_output)
    else $error("standard did not switch");
  dir_batt_a: assert property (
    (dir && vdd_below_vbat)[*8] |-> backed_supply_output) else $error("direct did not switch");
endmodule
bind bsc_top bsc_checker bsc_checker_i (.mclk(mclk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .vdd_below_vbat(vdd_below_vbat), .vdd_below_vth(vdd_below_vth),
  .backed_supply_output(backed_supply_output), .host_in_enable(host_in_enable),
  .host_out_enable(host_out_enable), .square_wave_output_enable(square_wave_output_enable));

// ===== verification/bsc_supply_mon.sv
// supply comparator model: millivolt levels in, comparator levels out
`timescale 1ns/1ps
module bsc_supply_mon #(
  parameter logic [15:0] VTH_MV = 16'h9c4,
  parameter logic [15:0] VLOW_MV = 16'h9c4
) (
  // clock
  input wire logic mclk,
  // levels and speed
  input wire logic [15:0] vdd_mv,
  input wire logic [15:0] vbat_mv,
  input wire logic slow,
  // comparator outputs
  output logic below_vbat,
  output logic below_vth,
  output logic bat_low
);
  logic [1:0] cnt = 2'h0;
  // a slow monitor refreshes only every fourth cycle
  always @(posedge mclk) begin
    cnt <= cnt + 2'h1;
    if (!slow || cnt == 2'h0) begin
      below_vbat <= vdd_mv < vbat_mv;
      below_vth <= vdd_mv < VTH_MV;
      bat_low <= vbat_mv < VLOW_MV;
    end
  end
endmodule

// ===== verification/tb_bsc_top.sv
// testbench for the battery switch-over control
`timescale 1ns/1ps
module tb_bsc_top
  import bsc_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr;
  logic rd, wr, wq, bso, hie, hoe, swe, irq, bv, bt, bl, slow;
  logic [31:0] wdata, rdata, q, tnow;
  logic [15:0] vdd, vbat;
  logic [3:0] be = 4'hf;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  bsc_supply_mon bsc_supply_mon_i (.mclk(mclk), .vdd_mv(vdd), .vbat_mv(vbat), .slow(slow),
    .below_vbat(bv), .below_vth(bt), .bat_low(bl));
  bsc_top bsc_top_i (.mclk(mclk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wq), .vdd_below_vbat(bv), .vdd_below_vth(bt), .vbat_low(bl),
    .current_time(tnow), .backed_supply_output(bso), .host_in_enable(hie),
    .host_out_enable(hoe), .square_wave_output_enable(swe), .irq(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge mclk); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // idle edges let registered flags and irq settle before checks
    repeat (2) @(posedge mclk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    ck(q, exp);
  endtask
  task automatic sup(input logic [15:0] d, input logic [15:0] b);
    vdd <= d;
    vbat <= b;
    repeat (12) @(posedge mclk);
  endtask
  initial begin
    addr = 5'h00;
    wdata = 32'h0;
    rd = 1'b0;
    wr = 1'b0;
    slow = 1'b0;
    tnow = 32'h0a1b2c3d;
    vdd = 16'hce4;
    vbat = 16'hbb8;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(BSC_CTRL_ADDR, 32'h7);
    rdc(BSC_IRQ_MASK_ADDR, 32'h0);
    rdc(5'h14, 32'h0);
    sup(16'h708, 16'h898);
    ck(bso, 1'b0);
    rdc(BSC_FLAGS_ADDR, 32'h0);
    sup(16'hce4, 16'hbb8);
    bus(1'b1, BSC_CTRL_ADDR, 32'h18);
    // byte lane 0 off: the write must be dropped
    be <= 4'he;
    bus(1'b1, BSC_CTRL_ADDR, 32'h0);
    be <= 4'hf;
    rdc(BSC_CTRL_ADDR, 32'h18);
    sup(16'haf0, 16'he10);
    ck(bso, 1'b0);
    sup(16'h7d0, 16'hbb8);
    ck({bso, hie, hoe, swe, irq}, 32'h11);
    tnow <= 32'h55aa55aa;
    rdc(BSC_FLAGS_ADDR, 32'h5);
    rdc(BSC_TIMESTAMP_ADDR, 32'h0a1b2c3d);
    sup(16'hce4, 16'hbb8);
    rdc(BSC_FLAGS_ADDR, 32'h1);
    ck(irq, 1'b1);
    bus(1'b1, BSC_FLAGS_ADDR, 32'h1);
    ck(irq, 1'b0);
    bus(1'b1, BSC_CTRL_ADDR, 32'h0);
    rdc(BSC_IRQ_STATUS_ADDR, 32'h5);
    slow <= 1'b1;
    sup(16'h7d0, 16'hbb8);
    ck(irq, 1'b0);
    bus(1'b1, BSC_IRQ_MASK_ADDR, 32'h1);
    ck(irq, 1'b1);
    rdc(BSC_IRQ_STATUS_ADDR, 32'h1);
    ck(irq, 1'b0);
    rdc(BSC_IRQ_STATUS_ADDR, 32'h0);
    rdc(BSC_TIMESTAMP_ADDR, 32'h0a1b2c3d);
    slow <= 1'b0;
    bus(1'b1, BSC_IRQ_MASK_ADDR, 32'h0);
    sup(16'hce4, 16'hbb8);
    bus(1'b1, BSC_FLAGS_ADDR, 32'h1);
    bus(1'b1, BSC_CTRL_ADDR, 32'h20);
    sup(16'hce4, 16'h7d0);
    rdc(BSC_FLAGS_ADDR, 32'h2);
    ck(irq, 1'b1);
    bus(1'b1, BSC_FLAGS_ADDR, 32'h2);
    rdc(BSC_FLAGS_ADDR, 32'h2);
    sup(16'hce4, 16'hbb8);
    rdc(BSC_FLAGS_ADDR, 32'h0);
    ck(irq, 1'b0);
    rdc(BSC_IRQ_STATUS_ADDR, 32'h2);
    for (int c = 0; c < 8; c++) begin
      // start each mode with the sticky switch flag cleared
      bus(1'b1, BSC_FLAGS_ADDR, 32'h1);
      bus(1'b1, BSC_CTRL_ADDR, 32'(c));
      // first case puts vdd below the battery but above the switch threshold, so only direct mode switches
      sup(16'haf0, 16'he10);
      ck(bso, c > 2 && c < 6);
      sup(16'h708, 16'h898);
      ck(bso, c < 6);
      rdc(BSC_FLAGS_ADDR, {29'h0, c < 6, c == 0 || c == 3, c < 6});
      sup(16'hce4, 16'hbb8);
      ck(bso, 1'b0);
    end
    final_report();
  end
endmodule
